// *** lpc_monitor_pkg.sv ***
// package: register map, field positions and reset values of the host bus fault monitor
// assumes: 32-bit apb data, one aligned word per register
package lpc_monitor_pkg;
  localparam logic [11:0] BUS_RESET_MONITOR_OFS = 12'h104;
  localparam logic [11:0] HOST_FAULT_CAPTURE_OFS = 12'h108;
  localparam logic [11:0] HOST_SERIAL_IRQ_DRIVE_OFS = 12'h10C;
  localparam int ADDR_W = 12;
  localparam int CAP_ADDR_W = 24;
  localparam int CAP_ADDR_LSB = 8;
  localparam int RESET_LEVEL_BIT = 1;
  localparam int DMA_FAULT_BIT = 5;
  localparam int CFG_FAULT_BIT = 4;
  localparam int IO_FAULT_BIT = 3;
  localparam int OVERLAP_BIT = 2;
  localparam int FAULT_EN_BIT = 1;
  localparam int SUMMARY_BIT = 0;
  localparam int SERIAL_IRQ_BIT = 0;
  localparam logic [31:0] REG_RESET_VAL = 32'h0000_0000;
  localparam logic [23:0] CAP_RESET_VAL = 24'h00_0000;
endpackage

// *** sticky_flag.sv ***
// sticky fault flag: set by hardware, cleared by a write of one
// assumes: set and clear are single-cycle qualified strobes
`timescale 1ns/1ps
`default_nettype none
module sticky_flag (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic setEvt,
  input wire logic clrEvt,
  output logic flag
);
  logic flag_ff;
  logic nxt_flag;
  // set wins over a clear in the same cycle
  assign nxt_flag = setEvt | (flag_ff & ~clrEvt); // [R11]
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      flag_ff <= 1'b0; // [R14]
    end else begin
      flag_ff <= nxt_flag;
    end
  end
  assign flag = flag_ff;
endmodule
`default_nettype wire

// *** lpc_bus_error_monitor.sv ***
// top: apb register bank for host bus reset view, fault capture and serial irq source bit
// assumes: fault strobes and host address are synchronous to sys_clk, one pulse per cycle
//
// Behaviour
// R1 - reset-status bit reads the inverse of the bus reset input
// R2 - while summary flag is clear, capture the 24-bit address of every host transaction
// R3 - while summary flag is set, hold the captured address
// R4 - capture field keeps the address of the first faulting access
// R5 - dma fault bit 5 set on dma internal error when reporting enabled
// R6 - config fault bit 4 set on config internal error when reporting enabled
// R7 - i/o fault bit 3 set on i/o internal error when reporting enabled
// R8 - overlap bit 2 set on multiple window match, regardless of enable
// R9 - enable bit 1 lets internal errors also set the summary flag
// R10 - summary bit 0 set on overlap or enabled internal error
// R11 - fault flags stay set until firmware writes one; zero leaves them
// R12 - summary flag drives a level interrupt request to the processor
// R13 - firmware bit 0 of serial irq register is the host request level
// R14 - all fields reset to zero on system reset; reserved bits read zero
`timescale 1ns/1ps
`default_nettype none
module lpc_bus_error_monitor
  import lpc_monitor_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic busResetIn_b,
  input wire logic hostCycleValid,
  input wire logic [CAP_ADDR_W-1:0] hostCycleAddr,
  input wire logic dmaIntErr,
  input wire logic cfgIntErr,
  input wire logic ioIntErr,
  input wire logic windowOverlap,
  output logic faultIrq,
  output logic serialIrqReq
);
  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  logic setupPhase;
  logic hitMon;
  logic hitCap;
  logic hitSirq;
  logic hitAny;
  logic wrCap;
  logic wrSirq;
  assign setupPhase = psel & ~penable;
  assign hitMon = (paddr == BUS_RESET_MONITOR_OFS);
  assign hitCap = (paddr == HOST_FAULT_CAPTURE_OFS);
  assign hitSirq = (paddr == HOST_SERIAL_IRQ_DRIVE_OFS);
  assign hitAny = hitMon | hitCap | hitSirq;
  // writes land at the access edge, which is the one with pready high
  assign wrCap = psel & penable & pready & pwrite & hitCap;
  assign wrSirq = psel & penable & pready & pwrite & hitSirq;

  // ------------------------------------------------------------
  // control and capture registers
  // ------------------------------------------------------------
  logic faultEn_ff;
  logic sirq_ff;
  logic [CAP_ADDR_W-1:0] capAddr_ff;
  logic [CAP_ADDR_W-1:0] nxt_capAddr;
  logic summary;
  assign nxt_capAddr = (hostCycleValid && !summary) ? hostCycleAddr : capAddr_ff; // [R2] [R3]

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      faultEn_ff <= 1'b0; // [R14]
      sirq_ff <= 1'b0;
      capAddr_ff <= CAP_RESET_VAL;
    end else begin
      capAddr_ff <= nxt_capAddr; // [R4]
      if (wrCap) begin
        faultEn_ff <= pwdata[FAULT_EN_BIT];
      end
      if (wrSirq) begin
        sirq_ff <= pwdata[SERIAL_IRQ_BIT]; // [R13]
      end
    end
  end

  // ------------------------------------------------------------
  // sticky fault flags
  // ------------------------------------------------------------
  logic [5:0] setVec;
  logic [5:0] flagVec;
  logic intErrAny;
  assign intErrAny = dmaIntErr | cfgIntErr | ioIntErr;
  always_comb begin
    setVec = 6'h00;
    setVec[DMA_FAULT_BIT] = faultEn_ff & dmaIntErr; // [R5]
    setVec[CFG_FAULT_BIT] = faultEn_ff & cfgIntErr; // [R6]
    setVec[IO_FAULT_BIT] = faultEn_ff & ioIntErr; // [R7]
    setVec[OVERLAP_BIT] = windowOverlap; // [R8]
    setVec[SUMMARY_BIT] = windowOverlap | (faultEn_ff & intErrAny); // [R9] [R10]
  end

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_flag
      if (gi != FAULT_EN_BIT) begin : g_sticky
        sticky_flag u_flag (
          .sys_clk(sys_clk),
          .rst_b(rst_b),
          .setEvt(setVec[gi]),
          .clrEvt(wrCap & pwdata[gi]), // [R11]
          .flag(flagVec[gi])
        );
      end else begin : g_en
        assign flagVec[gi] = faultEn_ff;
      end
    end
  endgenerate
  assign summary = flagVec[SUMMARY_BIT];

  // ------------------------------------------------------------
  // read data and outputs
  // ------------------------------------------------------------
  logic [31:0] monWord;
  logic [31:0] capWord;
  logic [31:0] sirqWord;
  logic [31:0] rdMux;
  always_comb begin
    monWord = REG_RESET_VAL;
    monWord[RESET_LEVEL_BIT] = ~busResetIn_b; // [R1]
    capWord = REG_RESET_VAL;
    capWord[CAP_ADDR_LSB +: CAP_ADDR_W] = capAddr_ff;
    capWord[5:0] = flagVec;
    sirqWord = REG_RESET_VAL; // [R14]
    sirqWord[SERIAL_IRQ_BIT] = sirq_ff;
  end
  assign rdMux = hitMon ? monWord : hitCap ? capWord : hitSirq ? sirqWord : REG_RESET_VAL;

  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic faultIrq_ff;
  logic serialIrqReq_ff;
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      prdata_ff <= REG_RESET_VAL;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      faultIrq_ff <= 1'b0;
      serialIrqReq_ff <= 1'b0;
    end else begin
      pready_ff <= setupPhase;
      pslverr_ff <= setupPhase & ~hitAny;
      if (setupPhase) begin
        prdata_ff <= pwrite ? REG_RESET_VAL : rdMux;
      end
      faultIrq_ff <= summary; // [R12]
      serialIrqReq_ff <= sirq_ff; // [R13]
    end
  end
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign faultIrq = faultIrq_ff;
  assign serialIrqReq = serialIrqReq_ff;
endmodule
`default_nettype wire

// *** lpc_mon_chk.sv ***
// checker: apb timing, read zeros and irq levels, bound to lpc_bus_error_monitor
`timescale 1ns/1ps
`default_nettype none
module lpc_mon_chk (
  input wire logic sys_clk, rst_b, psel, penable, pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic pready, windowOverlap, faultIrq, serialIrqReq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  wire clrW = pready && pwrite && paddr == 12'h108 && pwdata[0];
  wire serW = pready && pwrite && paddr == 12'h10C;
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready");
  property p_one; pready |-> penable && $past(psel && !penable); endproperty
  a_one: assert property (p_one) else $error("stray ready");
  property p_unm; pready && !pwrite && !(paddr inside {12'h104, 12'h108, 12'h10C}) |-> !prdata;
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped data");
  property p_res; pready && !pwrite && paddr == 12'h10C |-> prdata[31:1] == 31'h0; endproperty
  a_res: assert property (p_res) else $error("reserved bits");
  property p_ovl; windowOverlap |-> ##2 faultIrq; endproperty
  a_ovl: assert property (p_ovl) else $error("no irq");
  property p_hold; $fell(faultIrq) |-> $past(clrW, 2); endproperty
  a_hold: assert property (p_hold) else $error("irq dropped");
  property p_ser; serW |-> ##2 serialIrqReq == $past(pwdata[0], 2); endproperty
  a_ser: assert property (p_ser) else $error("serial level");
  property p_chg; $changed(serialIrqReq) |-> $past(serW, 2); endproperty
  a_chg: assert property (p_chg) else $error("serial moved");
  c_irq: cover property (windowOverlap ##2 faultIrq);
  c_clr: cover property ($fell(faultIrq));
  c_ser: cover property ($rose(serialIrqReq));
endmodule
`default_nettype wire

// *** lpc_host_model.sv ***
// partner: host side, one host cycle per call, drives the bus reset pin
`timescale 1ns/1ps
`default_nettype none
module lpc_host_model (
  input wire logic sys_clk,
  output logic busResetIn_b = 1'b1, hostCycleValid = 1'b0,
  output logic [23:0] hostCycleAddr = 24'h0,
  output logic dmaIntErr = 1'b0, cfgIntErr = 1'b0, ioIntErr = 1'b0, windowOverlap = 1'b0
);
  task pin(input logic b);
    @(posedge sys_clk);
    busResetIn_b <= b;
  endtask
  // e is overlap, dma, cfg, io; released address is inverted
  task cyc(input logic [23:0] a, input logic [3:0] e);
    @(posedge sys_clk);
    {hostCycleValid, hostCycleAddr, windowOverlap, dmaIntErr, cfgIntErr, ioIntErr} <= {1'b1, a, e};
    @(posedge sys_clk);
    {hostCycleValid, hostCycleAddr, windowOverlap, dmaIntErr, cfgIntErr, ioIntErr} <= {1'b0, ~a, 4'h0};
  endtask
endmodule
`default_nettype wire

// *** lpc_bus_error_monitor_test.sv ***
// testbench: register tests of the host bus fault monitor over apb
// assumes: host model on the host side, checker bound at the foot
`timescale 1ns/1ps
`default_nettype none
module lpc_bus_error_monitor_test;
  logic sys_clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, s;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, q;
  wire [31:0] prdata;
  wire [23:0] hostCycleAddr;
  wire pready, pslverr, busResetIn_b, hostCycleValid, dmaIntErr, cfgIntErr, ioIntErr;
  wire windowOverlap, faultIrq, serialIrqReq;
  int err_total = 0, n_checks = 0;
  always #50 sys_clk = ~sys_clk;
  lpc_host_model i_lpc_host_model (.*);
  lpc_bus_error_monitor i_lpc_bus_error_monitor (.*);
  task chk(input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d, input logic w = 1'b1);
    @(posedge sys_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    q = prdata;
    s = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    wr(a, 32'h0, 1'b0);
    chk(q, e);
  endtask
  task results;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    err_total++;
    results();
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(12'h104, 32'h0);
    rd(12'h108, 32'h0);
    rd(12'h10C, 32'h0);
    i_lpc_host_model.pin(1'b0);
    rd(12'h104, 32'h2);
    i_lpc_host_model.pin(1'b1);
    wr(12'h104, 32'hFFFFFFFF);
    rd(12'h104, 32'h0);
    $display("reset test end");
    i_lpc_host_model.cyc(24'hABCDEF, 4'h0);
    rd(12'h108, 32'hABCDEF00);
    i_lpc_host_model.cyc(24'h123456, 4'h7);
    rd(12'h108, 32'h12345600);
    i_lpc_host_model.cyc(24'h111111, 4'h8);
    i_lpc_host_model.cyc(24'h222222, 4'h0);
    rd(12'h108, 32'h11111105);
    chk({31'h0, faultIrq}, 32'h1);
    wr(12'h108, 32'h0);
    rd(12'h108, 32'h11111105);
    wr(12'h108, 32'h5);
    rd(12'h108, 32'h11111100);
    chk({31'h0, faultIrq}, 32'h0);
    wr(12'h108, 32'h2);
    for (int i = 0; i < 3; i++) begin
      i_lpc_host_model.cyc(24'h00A000 + 24'(i), 4'h1 << i);
      i_lpc_host_model.cyc(24'h0F0F0F, 4'h1);
      rd(12'h108, {24'h00A000 + 24'(i), 8'h0B | (8'h08 << i)});
      wr(12'h108, 32'h3B);
      rd(12'h108, {24'h00A000 + 24'(i), 8'h02});
    end
    wr(12'h10C, 32'hFFFFFFFF);
    rd(12'h10C, 32'h1);
    chk({31'h0, serialIrqReq}, 32'h1);
    wr(12'h10C, 32'h0);
    rd(12'h10C, 32'h0);
    chk({31'h0, serialIrqReq}, 32'h0);
    rd(12'h110, 32'h0);
    chk({31'h0, s}, 32'h1);
    $display("fault test end");
    results();
  end
endmodule
bind lpc_bus_error_monitor lpc_mon_chk i_lpc_mon_chk (.*);
`default_nettype wire
